// file: pmc_far_side.sv
// Far side model: other devices and the host on the flag and data pins.
`timescale 1ns/100ps
module pmc_far_side (
  input  wire logic        core_clk_i,   // Processor clock.
  input  wire logic [7:0]  ext_lvl_i,    // Levels other devices put on flag pins.
  input  wire logic [3:0]  host_str_n_i, // Host strobes wr, rd, al, sel; al active high, the rest active low.
  input  wire logic [7:0]  flag_o_i,     // Block flag drive levels.
  input  wire logic [7:0]  flag_oe_i,    // Block flag drive enables.
  input  wire logic [23:0] data_o_i,     // Block data drive levels.
  input  wire logic [23:0] data_oe_i,    // Block data drive enables.
  output logic      [7:0]  flag_pin_o,   // Resolved flag wires.
  output logic      [23:0] data_pin_o    // Resolved data wires.
);
  // Undriven data lines toggle every cycle so no stale value survives.
  logic [23:0] junk_q = 24'h5A5A5A;
  always @(posedge core_clk_i) junk_q <= ~junk_q;
  // Flag wires: block drive where enabled, else the pulled-up external level.
  assign flag_pin_o = (flag_oe_i & flag_o_i) | (~flag_oe_i & ext_lvl_i);
  // The host owns the four strobe lines in host mode.
  assign data_pin_o = {(data_oe_i[23:8] & data_o_i[23:8]) | (~data_oe_i[23:8] & junk_q[23:8]), host_str_n_i,
                       (data_oe_i[3:0] & data_o_i[3:0]) | (~data_oe_i[3:0] & junk_q[3:0])};
endmodule : pmc_far_side

// file: pmc_pin_mode_configuration.sv
// Pin mode configuration block: strap capture, flag pins, shared interrupts and pin multiplexing.
//
// Overview of operation
// - Memory mode strap at reset fixes mode.
// - Strap pins become flags zero to three.
// - Shared pins act as flag and interrupt.
// - Enabled shared interrupt requests its vector.
// - Flag seven configurable, six five level, four edge.
// - Full mode: 14 address, 24 data lines.
// - Full mode byte transfers, host mode direct port.
// - Host mode: 16 pin multiplexed host bus.
// - Acknowledge open source, option from strap D.
// - Control bit picks serial port pin function.
// - Alternate: two interrupts, flag in, flag out.
`timescale 1ns/100ps
module pmc_pin_mode_configuration (
  input  wire logic                           core_clk_i,       // Processor clock, 100 MHz.
  input  wire logic                           reset_n_i,        // Synchronous reset, active low.
  input  wire logic                           clk_en_i,         // Freezes all state while low, but reset still acts.
  input  wire logic [pmc_pkg::ADDR_W-1:0]     reg_addr_i,       // Register byte address.
  input  wire logic [pmc_pkg::DATA_W-1:0]     reg_wdata_i,      // Register write data.
  input  wire logic                           reg_wr_i,         // Register write strobe.
  input  wire logic                           reg_rd_i,         // Register read strobe.
  output logic      [pmc_pkg::DATA_W-1:0]     reg_rdata_o,      // Read data, cycle after strobe.
  input  wire logic [7:0]                     prog_flag_pins_i, // Flag pin levels.
  output logic      [7:0]                     prog_flag_pins_o, // Flag pin drive levels.
  output logic      [7:0]                     prog_flag_pins_oe_o, // Flag pin drive enables.
  output logic      [7:0]                     flag_in_o,        // Flag levels to the core.
  input  wire logic [13:0]                    ext_addr_pins_i,  // Address pin levels.
  output logic      [13:0]                    ext_addr_pins_o,  // Address pin drive levels.
  output logic      [13:0]                    ext_addr_pins_oe_o, // Address pin drive enables.
  input  wire logic [23:0]                    ext_data_pins_i,  // Data pin levels.
  output logic      [23:0]                    ext_data_pins_o,  // Data pin drive levels.
  output logic      [23:0]                    ext_data_pins_oe_o, // Data pin drive enables.
  input  wire pmc_pkg::pmc_mem_req_t          mem_req_i,        // Core memory request.
  output logic      [23:0]                    mem_rdata_o,      // Sampled data pins to the core.
  input  wire logic [15:0]                    host_rdata_i,     // Host port read data from core.
  input  wire logic                           host_rdata_oe_i,  // Core drives host read data.
  input  wire logic                           host_ack_i,       // Core acknowledges host access.
  output pmc_pkg::pmc_host_req_t              host_req_o,       // Host port inputs to the core.
  output logic                                host_mode_o,      // Host mode latched at reset.
  input  wire logic                           sp1_rfs_pin_i,    // Serial one receive frame pin.
  input  wire logic                           sp1_tfs_pin_i,    // Serial one transmit frame pin.
  input  wire logic                           sp1_dr_pin_i,     // Serial one receive data pin.
  output logic                                sp1_dt_pin_o,     // Serial one transmit data pin.
  input  wire logic                           sport_dt_i,       // Transmit data from serial core.
  output logic      [2:0]                     sport_in_o,       // Frame and data pins to serial core.
  output logic                                serial_alt_flag_in_o, // Alternate flag in level.
  output logic      [pmc_pkg::IRQ_N-1:0]      irq_pending_o,    // Enabled pending interrupts.
  output logic                                irq_o             // Level interrupt output.
);

  // ----------------------------------------------------------------------
  // Pin synchronisers.
  // ----------------------------------------------------------------------
  localparam int SYN_W = 8 + 14 + 24 + 3;            // All pins that enter from outside.
  logic [SYN_W-1:0] syn1_q;                          // First stage, read only by the second.
  logic [SYN_W-1:0] syn2_q;                          // Second stage, safe to use.
  wire  [SYN_W-1:0] pins_raw = {sp1_rfs_pin_i, sp1_tfs_pin_i, sp1_dr_pin_i,
                                ext_data_pins_i, ext_addr_pins_i, prog_flag_pins_i};
  wire  [7:0]       pf_s     = syn2_q[7:0];          // Synchronised flag pins.
  wire  [13:0]      addr_s   = syn2_q[21:8];         // Synchronised address pins.
  wire  [23:0]      data_s   = syn2_q[45:22];        // Synchronised data pins.
  wire  [2:0]       sp_s     = syn2_q[48:46];        // Synchronised rfs, tfs, dr.

  // The synchroniser runs through reset so the straps can be sampled there.
  always_ff @(posedge core_clk_i) begin
    if (clk_en_i) begin
      syn1_q <= pins_raw;
      syn2_q <= syn1_q;
    end
  end

  // ----------------------------------------------------------------------
  // Strap capture.
  // ----------------------------------------------------------------------
  logic [3:0] strap_q;                               // Strap levels held since release.

  // Straps follow the pins while reset is low and freeze at its release.
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      strap_q <= pf_s[3:0];
    end
  end
  wire host_mode = strap_q[pmc_pkg::STRAP_C_BIT];    // Memory mode from strap C.
  wire ack_opt   = strap_q[pmc_pkg::STRAP_D_BIT];    // Acknowledge option from strap D.

  // ----------------------------------------------------------------------
  // Register file.
  // ----------------------------------------------------------------------
  logic [7:0]                 dir_q;                 // Flag directions.
  logic [7:0]                 fout_q;                // Flag output levels.
  logic [pmc_pkg::CTRL_W-1:0] ctrl_q;                // System control field.
  logic [pmc_pkg::IRQ_N-1:0]  en_q;                  // Interrupt enable mask.
  logic [pmc_pkg::IRQ_N-1:0]  stat_q;                // Sticky interrupt status.
  logic [pmc_pkg::DATA_W-1:0] rdata_q;               // Read data register.
  wire  wr_dir  = reg_wr_i && (reg_addr_i == pmc_pkg::OFS_FLAG_DIR);
  wire  wr_fout = reg_wr_i && (reg_addr_i == pmc_pkg::OFS_FLAG_OUT);
  wire  wr_ctrl = reg_wr_i && (reg_addr_i == pmc_pkg::OFS_SYS_CTRL);
  wire  wr_en   = reg_wr_i && (reg_addr_i == pmc_pkg::OFS_INT_EN);
  wire  wr_clr  = reg_wr_i && (reg_addr_i == pmc_pkg::OFS_INT_CLR);
  wire  [7:0] wdata8 = reg_wdata_i[7:0];             // Low byte of write data.

  // Read mux; unmapped and write-only offsets read as zero.
  logic [pmc_pkg::DATA_W-1:0] rdata_d;
  always_comb begin
    rdata_d = '0;
    case (reg_addr_i)
      pmc_pkg::OFS_MODE:     rdata_d[4:0] = {host_mode, strap_q};
      pmc_pkg::OFS_FLAG_DIR: rdata_d[7:0] = dir_q;
      pmc_pkg::OFS_FLAG_OUT: rdata_d[7:0] = fout_q;
      pmc_pkg::OFS_FLAG_IN:  rdata_d[7:0] = pf_s;
      pmc_pkg::OFS_SYS_CTRL: rdata_d[pmc_pkg::CTRL_W-1:0] = ctrl_q;
      pmc_pkg::OFS_INT_EN:   rdata_d[pmc_pkg::IRQ_N-1:0] = en_q;
      pmc_pkg::OFS_INT_STAT: rdata_d[pmc_pkg::IRQ_N-1:0] = stat_q;
      default:               rdata_d = '0;
    endcase
  end

  // Writable registers; directions reset to inputs.
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      dir_q   <= pmc_pkg::FLAG_DIR_RST;
      fout_q  <= pmc_pkg::FLAG_OUT_RST;
      ctrl_q  <= pmc_pkg::CTRL_RST;
      en_q    <= pmc_pkg::INT_EN_RST;
      rdata_q <= '0;
    end else if (clk_en_i) begin
      if (wr_dir)  dir_q  <= wdata8;
      if (wr_fout) fout_q <= wdata8;
      if (wr_ctrl) ctrl_q <= reg_wdata_i[pmc_pkg::CTRL_W-1:0];
      if (wr_en)   en_q   <= reg_wdata_i[pmc_pkg::IRQ_N-1:0];
      rdata_q <= reg_rd_i ? rdata_d : '0;
    end
  end

  // ----------------------------------------------------------------------
  // Shared interrupt and flag logic.
  // ----------------------------------------------------------------------
  // A driven flag feeds its own value back, so software can raise its interrupt.
  wire  [7:0] lvl = (dir_q & fout_q) | (~dir_q & pf_s);
  wire        alt = ctrl_q[pmc_pkg::CTRL_SER_ALT];
  // Interrupt requests, active high, in status bit order.
  // Flag pins are active low; serial pins only request while the alternate function is on.
  wire  [pmc_pkg::IRQ_N-1:0] req_lvl = {alt & ~sp_s[1], alt & ~sp_s[2], ~lvl[4], ~lvl[5], ~lvl[6], ~lvl[7]};
  logic [pmc_pkg::IRQ_N-1:0] req_prev_q;             // Request one cycle earlier.
  wire  [pmc_pkg::IRQ_N-1:0] req_rise = req_lvl & ~req_prev_q;
  // Per source edge select; six and five are always level, four always edge.
  wire  [pmc_pkg::IRQ_N-1:0] is_edge = {ctrl_q[pmc_pkg::CTRL_S1_EDGE], ctrl_q[pmc_pkg::CTRL_S0_EDGE],
                                        1'b1, 1'b0, 1'b0, ctrl_q[pmc_pkg::CTRL_EL_EDGE]};
  wire  [pmc_pkg::IRQ_N-1:0] ev = (is_edge & req_rise) | (~is_edge & req_lvl);
  wire  [pmc_pkg::IRQ_N-1:0] clr = wr_clr ? reg_wdata_i[pmc_pkg::IRQ_N-1:0] : '0;
  wire  [pmc_pkg::IRQ_N-1:0] stat_d = (stat_q & ~clr) | ev;   // Set wins over clear.
  wire  [pmc_pkg::IRQ_N-1:0] pend_d = stat_d & en_q;

  // Status, pending requests and the interrupt line.
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      req_prev_q    <= '0;
      stat_q        <= '0;
      irq_pending_o <= '0;
      irq_o         <= 1'b0;
      flag_in_o     <= '0;
    end else if (clk_en_i) begin
      req_prev_q    <= req_lvl;
      stat_q        <= stat_d;
      irq_pending_o <= pend_d;
      irq_o         <= |pend_d;
      flag_in_o     <= lvl;
    end
  end

  // ----------------------------------------------------------------------
  // Memory and host port pin multiplexing.
  // ----------------------------------------------------------------------
  // Full mode drives all address pins and puts byte address bits on the top data byte.
  wire [23:0] full_dout = {mem_req_i.byte_access ? mem_req_i.byte_hi : mem_req_i.data[23:16],
                           mem_req_i.data[15:0]};
  wire [23:0] full_doe  = {{8{mem_req_i.data_oe | mem_req_i.byte_access}}, {16{mem_req_i.data_oe}}};
  // Acknowledge is open source: it only ever drives high, strap D picks when.
  wire        ack_oe    = ack_opt ? ~host_ack_i : host_ack_i;
  // Host mode turns address 13:1 and data 2:0 into the host bus, data 7:3 into control.
  wire [23:0] host_dout = {mem_req_i.data[23:8], 4'h0, 1'b1, host_rdata_i[15:13]};
  wire [23:0] host_doe  = {{16{mem_req_i.data_oe}}, 4'h0, ack_oe, {3{host_rdata_oe_i}}};
  wire [13:0] addr_d    = host_mode ? {host_rdata_i[12:0], mem_req_i.addr[0]} : mem_req_i.addr;
  wire [13:0] addr_oe_d = host_mode ? {{13{host_rdata_oe_i}}, 1'b1} : 14'h3FFF;
  wire [23:0] data_d    = host_mode ? host_dout : full_dout;
  wire [23:0] data_oe_d = host_mode ? host_doe : full_doe;
  wire pmc_pkg::pmc_host_req_t host_d = host_mode ?
       '{addr_data: {data_s[2:0], addr_s[13:1]}, wr: ~data_s[7], rd: ~data_s[6],
         al: data_s[5], sel: ~data_s[4]} : '0;

  // Pin drivers; all enables low during reset so the pins float.
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      ext_addr_pins_o     <= '0;
      ext_addr_pins_oe_o  <= '0;
      ext_data_pins_o     <= '0;
      ext_data_pins_oe_o  <= '0;
      prog_flag_pins_o    <= pmc_pkg::FLAG_OUT_RST;
      prog_flag_pins_oe_o <= pmc_pkg::FLAG_DIR_RST;
      host_req_o          <= '0;
      host_mode_o         <= 1'b0;
      mem_rdata_o         <= '0;
    end else if (clk_en_i) begin
      ext_addr_pins_o     <= addr_d;
      ext_addr_pins_oe_o  <= addr_oe_d;
      ext_data_pins_o     <= data_d;
      ext_data_pins_oe_o  <= data_oe_d;
      prog_flag_pins_o    <= fout_q;
      prog_flag_pins_oe_o <= dir_q;
      host_req_o          <= host_d;
      host_mode_o         <= host_mode;
      mem_rdata_o         <= data_s;
    end
  end

  // ----------------------------------------------------------------------
  // Serial port one pin function.
  // ----------------------------------------------------------------------
  // The clock pin is not touched, so the internal serial clock stays usable.
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      sp1_dt_pin_o         <= 1'b0;
      sport_in_o           <= '0;
      serial_alt_flag_in_o <= 1'b0;
    end else if (clk_en_i) begin
      sp1_dt_pin_o         <= alt ? ctrl_q[pmc_pkg::CTRL_FO_BIT] : sport_dt_i;
      sport_in_o           <= alt ? 3'h0 : sp_s;
      serial_alt_flag_in_o <= alt & sp_s[0];
    end
  end
  assign reg_rdata_o = rdata_q;

  // ----------------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  a_mode_held_stable: assert property ($past(reset_n_i) |-> $stable(strap_q))
    else $error("Strap latch changed while running.");
  a_flag_start_input: assert property ($rose(reset_n_i) |-> prog_flag_pins_oe_o == 8'h00)
    else $error("Flag pin driven right after reset.");
  a_flag_dir_write: assert property (clk_en_i && wr_dir ##1 clk_en_i |=> prog_flag_pins_oe_o == $past(wdata8, 2))
    else $error("Flag direction write not on pins.");
  a_level_irq_set: assert property (clk_en_i && req_lvl[pmc_pkg::IRQ_L0] |=> stat_q[pmc_pkg::IRQ_L0])
    else $error("Level interrupt not flagged.");
  a_edge_only_rise: assert property (clk_en_i && !stat_q[pmc_pkg::IRQ_E] && !req_rise[pmc_pkg::IRQ_E]
                                     |=> !stat_q[pmc_pkg::IRQ_E])
    else $error("Edge interrupt set without an edge.");
  a_set_beats_clr: assert property (clk_en_i && wr_clr && ev[pmc_pkg::IRQ_E] |=> stat_q[pmc_pkg::IRQ_E])
    else $error("Clear beat a new event.");
  a_irq_vector_req: assert property (clk_en_i && |(stat_d & en_q) |=> irq_o)
    else $error("Enabled interrupt did not raise the line.");
  a_full_addr_drive: assert property (clk_en_i && !host_mode |=> ext_addr_pins_oe_o == 14'h3FFF)
    else $error("Address pins not driven in full mode.");
  a_host_ctl_inputs: assert property (host_mode_o |-> ext_data_pins_oe_o[7:4] == 4'h0)
    else $error("Host control pins driven.");
  a_ack_open_source: assert property (ext_data_pins_oe_o[3] |-> host_mode_o && ext_data_pins_o[3])
    else $error("Acknowledge driven low or outside host mode.");
  a_serial_alt_out: assert property (clk_en_i && alt |=> sp1_dt_pin_o == $past(ctrl_q[pmc_pkg::CTRL_FO_BIT]) && sport_in_o == 3'h0)
    else $error("Serial alternate function wrong.");

endmodule : pmc_pin_mode_configuration

// file: pmc_pin_mode_configuration_bench.sv
// Self-checking testbench of the pin mode block.
`timescale 1ns/100ps
module pmc_pin_mode_configuration_bench;
  logic core_clk_i = 1'b0, reset_n_i = 1'b0, clk_en_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, rd_seen = 1'b0;
  logic [7:0] reg_addr_i = 8'h00, ext_lvl = 8'hFF, r, prog_flag_pins_i, prog_flag_pins_o, prog_flag_pins_oe_o, flag_in_o;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
  logic [13:0] ext_addr_pins_i, ext_addr_pins_o, ext_addr_pins_oe_o;
  logic [23:0] ext_data_pins_i, ext_data_pins_o, ext_data_pins_oe_o, mem_rdata_o;
  logic [15:0] host_rdata_i = 16'h0;
  logic [3:0] host_str_n = 4'hF;
  logic host_rdata_oe_i = 1'b0, host_ack_i = 1'b0, sp1_rfs_pin_i = 1'b1, sp1_tfs_pin_i = 1'b1, sp1_dr_pin_i = 1'b0;
  logic sport_dt_i = 1'b0, sp1_dt_pin_o, host_mode_o, serial_alt_flag_in_o, irq_o;
  logic [2:0] sport_in_o;
  logic [5:0] irq_pending_o;
  logic [31:0] exp_q[$]; // Expected read data, oldest first.
  pmc_pkg::pmc_mem_req_t mem_req_i = '0;
  pmc_pkg::pmc_host_req_t host_req_o;
  int fail_count = 0, checked = 0;
  always #5 core_clk_i = ~core_clk_i;
  assign ext_addr_pins_i = ext_addr_pins_o;
  pmc_pin_mode_configuration uut (.*);
  pmc_far_side far (.core_clk_i, .ext_lvl_i(ext_lvl), .host_str_n_i(host_str_n), .flag_o_i(prog_flag_pins_o),
    .flag_oe_i(prog_flag_pins_oe_o), .data_o_i(ext_data_pins_o), .data_oe_i(ext_data_pins_oe_o),
    .flag_pin_o(prog_flag_pins_i), .data_pin_o(ext_data_pins_i));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    exp_q.push_back(e);
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
  endtask : rd
  task automatic do_reset(input logic [3:0] strap);
    ext_lvl <= {4'hF, strap};
    reset_n_i <= 1'b0;
    repeat (10) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
  endtask : do_reset
  // Bounded wait for the interrupt line; a timeout ends the run.
  task automatic wait_irq(input logic lvl);
    for (int n = 0; n < 10 && irq_o !== lvl; n++) @(posedge core_clk_i);
    chk("irq_o", 32'(lvl), 32'(irq_o));
    if (irq_o !== lvl) close_out();
  endtask : wait_irq
  // Read data stand one cycle after the strobe; compare against the oldest note.
  always @(posedge core_clk_i) begin
    if (rd_seen && exp_q.size() > 0) chk("read data", exp_q.pop_front(), reg_rdata_o);
    rd_seen <= reg_rd_i;
  end
  initial begin
    r = 8'($urandom(47670));
    r = 8'($urandom);
    do_reset(4'h4);
    ext_lvl[3:0] <= 4'h0;
    repeat (4) @(posedge core_clk_i);
    rd(pmc_pkg::OFS_MODE, 32'h14);
    rd(pmc_pkg::OFS_FLAG_DIR, 32'h0);
    rd(pmc_pkg::OFS_INT_CLR, 32'h0);
    rd(8'h20, 32'h0);
    host_ack_i <= 1'b1;
    host_str_n <= 4'h7;
    repeat (4) @(posedge core_clk_i);
    chk("addr oe", 32'h1, 32'(ext_addr_pins_oe_o));
    chk("ack", 32'h3, {30'h0, ext_data_pins_oe_o[3], ext_data_pins_o[3]});
    chk("host strobes", 32'hA, {28'h0, host_req_o.wr, host_req_o.rd, host_req_o.al, host_req_o.sel});
    host_str_n <= 4'hF;
    wr(pmc_pkg::OFS_INT_EN, 32'h3F);
    wr(pmc_pkg::OFS_FLAG_DIR, 32'h1F);
    wr(pmc_pkg::OFS_FLAG_OUT, {24'h0, 3'h7, 1'b0, r[3:0]});
    chk("flag oe", 32'h1F, 32'(prog_flag_pins_oe_o));
    wait_irq(1'b1);
    chk("irq pending", 32'h8, 32'(irq_pending_o));
    chk("flag in", {24'h0, 3'h7, 1'b0, r[3:0]}, 32'(flag_in_o));
    rd(pmc_pkg::OFS_INT_STAT, 32'h8);
    rd(pmc_pkg::OFS_FLAG_IN, {24'h0, 3'h7, 1'b0, r[3:0]});
    wr(pmc_pkg::OFS_INT_CLR, 32'h8);
    wait_irq(1'b0);
    ext_lvl[6] <= 1'b0;
    wait_irq(1'b1);
    wr(pmc_pkg::OFS_INT_CLR, 32'h2);
    rd(pmc_pkg::OFS_INT_STAT, 32'h2);
    ext_lvl[6] <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    wr(pmc_pkg::OFS_INT_CLR, 32'h2);
    rd(pmc_pkg::OFS_INT_STAT, 32'h0);
    wr(pmc_pkg::OFS_SYS_CTRL, 32'h11);
    sp1_dr_pin_i <= 1'b1;
    sp1_rfs_pin_i <= 1'b0;
    repeat (5) @(posedge core_clk_i);
    chk("serial alt", 32'h18, {27'h0, sp1_dt_pin_o, serial_alt_flag_in_o, sport_in_o});
    rd(pmc_pkg::OFS_INT_STAT, 32'h10);
    mem_req_i.byte_hi <= r;
    mem_req_i.byte_access <= 1'b1;
    do_reset(4'h0);
    repeat (2) @(posedge core_clk_i);
    chk("full mode", {1'h0, 1'b0, 14'h3FFF, 8'hFF, r},
        {1'h0, host_mode_o, ext_addr_pins_oe_o, ext_data_pins_oe_o[23:16], ext_data_pins_o[23:16]});
    repeat (3) @(posedge core_clk_i);
    close_out();
  end
endmodule : pmc_pin_mode_configuration_bench

// file: pmc_pkg.sv
// Package with register map, field positions, reset values and carrier types of the pin mode block.
package pmc_pkg;

  // ----------------------------------------------------------------------
  // Register bus geometry.
  // ----------------------------------------------------------------------
  localparam int          ADDR_W        = 8;       // Register address width.
  localparam int          DATA_W        = 32;      // Register data width.

  // ----------------------------------------------------------------------
  // Register byte offsets.
  // ----------------------------------------------------------------------
  localparam logic [7:0]  OFS_MODE      = 8'h00;   // Latched straps and mode, read only.
  localparam logic [7:0]  OFS_FLAG_DIR  = 8'h04;   // Flag pin direction, one means output.
  localparam logic [7:0]  OFS_FLAG_OUT  = 8'h08;   // Flag pin output levels.
  localparam logic [7:0]  OFS_FLAG_IN   = 8'h0C;   // Flag pin sampled levels, read only.
  localparam logic [7:0]  OFS_SYS_CTRL  = 8'h10;   // Serial port function and edge selects.
  localparam logic [7:0]  OFS_INT_EN    = 8'h14;   // Interrupt enable mask.
  localparam logic [7:0]  OFS_INT_STAT  = 8'h18;   // Sticky interrupt status, read only.
  localparam logic [7:0]  OFS_INT_CLR   = 8'h1C;   // Interrupt clear, write only.

  // ----------------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------------
  localparam int          STRAP_C_BIT   = 2;       // Memory mode strap on flag two.
  localparam int          STRAP_D_BIT   = 3;       // Acknowledge option strap on flag three.
  localparam int          MODE_HOST_BIT = 4;       // Host mode bit in the mode register.
  localparam int          CTRL_SER_ALT  = 0;       // Serial port one alternate function.
  localparam int          CTRL_EL_EDGE  = 1;       // Flag seven interrupt is edge sensitive.
  localparam int          CTRL_S0_EDGE  = 2;       // Serial alternate interrupt zero edge select.
  localparam int          CTRL_S1_EDGE  = 3;       // Serial alternate interrupt one edge select.
  localparam int          CTRL_FO_BIT   = 4;       // Serial alternate flag out level.
  localparam int          CTRL_W        = 5;       // Width of the control register.
  localparam int          IRQ_EL        = 0;       // Edge or level interrupt on flag seven.
  localparam int          IRQ_L0        = 1;       // Level interrupt zero on flag six.
  localparam int          IRQ_L1        = 2;       // Level interrupt one on flag five.
  localparam int          IRQ_E         = 3;       // Edge interrupt on flag four.
  localparam int          IRQ_S0        = 4;       // Serial alternate interrupt zero.
  localparam int          IRQ_S1        = 5;       // Serial alternate interrupt one.
  localparam int          IRQ_N         = 6;       // Number of interrupt sources.

  // ----------------------------------------------------------------------
  // Reset values.
  // ----------------------------------------------------------------------
  localparam logic [7:0]  FLAG_DIR_RST  = 8'h00;   // All flags start as inputs.
  localparam logic [7:0]  FLAG_OUT_RST  = 8'hFF;   // Outputs idle high, the inactive level.
  localparam logic [4:0]  CTRL_RST      = 5'h00;   // Serial port function after reset.
  localparam logic [5:0]  INT_EN_RST    = 6'h00;   // All interrupts masked.

  // ----------------------------------------------------------------------
  // Carrier types.
  // ----------------------------------------------------------------------
  // Core side request for the external memory pins.
  typedef struct packed {
    logic [13:0] addr;         // Word address for all memory spaces.
    logic [23:0] data;         // Write data.
    logic        data_oe;      // Core drives write data.
    logic [7:0]  byte_hi;      // Upper byte memory address bits.
    logic        byte_access;  // Byte memory cycle in progress.
  } pmc_mem_req_t;

  // Host port inputs as seen by the core, all strobes active high.
  typedef struct packed {
    logic [15:0] addr_data;    // Multiplexed host address and data.
    logic        wr;           // Host write strobe asserted.
    logic        rd;           // Host read strobe asserted.
    logic        al;           // Host address latch asserted.
    logic        sel;          // Host port selected.
  } pmc_host_req_t;

endpackage : pmc_pkg
